// >>> rtl/bai_pkg.sv
// Constants, types and carriers for the byte ALU with indirect load.
// Assumes one core clock, a synchronous data memory with one-cycle read latency,
// and a decoder that presents one operation at a time.
//
// Contract
// RQ1 - A 7-bit location picks the source and a target bit sends the result to the accumulator (0) or back (1).
// RQ2 - Increment adds one to the location, delivers the sum to the target and updates the nil flag.
// RQ3 - Accumulator OR combines accumulator and location, delivers to the target and updates the nil flag.
// RQ4 - Left shift moves bit 7 to carry, bits 6..0 up by one, zero into bit 0, and updates carry and nil.
// RQ5 - Right shift moves bit 0 to carry, bits 7..1 down by one, zero into bit 7, and updates carry and nil.
// RQ6 - Copy passes the location unchanged to the target and updates the nil flag even on write-back.
// RQ7 - The two indirect window locations have no storage and reach the address held in their pointer.
// RQ8 - Indirect load copies the byte at the effective address of the chosen pointer into the accumulator.
// RQ9 - Update code 00 pre-increments, 01 pre-decrements, 10 post-increments, 11 post-decrements, kept after.
// RQ10 - Relative form addresses pointer plus a signed offset from -32 to 31 and leaves the pointer as it was.
// RQ11 - Pointer arithmetic is 16 bits wide and wraps at both ends.
// RQ12 - Pointer adjustment touches no status flag; only the loaded data changes the nil flag.
// RQ13 - The nil flag is set when the 8-bit result is zero, else cleared; other operations keep carry.
package bai_pkg;

   // ************************************************************
   // Widths, locations and reset values
   // ************************************************************
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 16;
   localparam int          LOC_W        = 7;
   localparam logic [6:0]  WIN0_LOC     = 7'h00;
   localparam logic [6:0]  WIN1_LOC     = 7'h01;
   localparam logic [8:0]  LOC_EXT      = 9'h000;
   localparam logic [15:0] PTR_STEP     = 16'h0001;
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic [15:0] PTR_RST      = 16'h0000;
   localparam logic        CARRY_RST    = 1'b0;
   localparam logic        NIL_RST      = 1'b0;
   localparam logic [7:0]  NIL_VALUE    = 8'h00;

   // ************************************************************
   // Enumerations
   // ************************************************************
   typedef enum logic [2:0] {
      OP_INCREMENT  = 3'h0,
      OP_OR_ACCUM   = 3'h1,
      OP_SHIFT_LEFT = 3'h2,
      OP_SHIFT_RGHT = 3'h3,
      OP_COPY_FILE  = 3'h4,
      OP_LOAD_INDIR = 3'h5
   } bai_op_t;

   typedef enum logic [1:0] {
      UPD_PRE_INC  = 2'h0,
      UPD_PRE_DEC  = 2'h1,
      UPD_POST_INC = 2'h2,
      UPD_POST_DEC = 2'h3
   } bai_upd_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'h0,
      ST_FETCH = 2'h1,
      ST_EXEC  = 2'h3
   } bai_state_t;

   typedef enum logic [1:0] {
      PRE_ACC  = 2'h0,
      PRE_PTR0 = 2'h1,
      PRE_PTR1 = 2'h2
   } bai_pre_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      logic        valid;
      bai_op_t     op;
      logic [6:0]  loc;
      logic        dest;
      logic        ptr_sel;
      logic        rel;
      bai_upd_t    upd;
      logic [5:0]  offset;
   } bai_op_req_t;

   typedef struct packed {
      logic        valid;
      bai_pre_t    target;
      logic [15:0] data;
   } bai_preset_t;

   typedef struct packed {
      logic        re;
      logic        we;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bai_mem_req_t;

   typedef struct packed {
      logic [7:0]  acc;
      logic        carry;
      logic        nil;
      logic [15:0] ptr0;
      logic [15:0] ptr1;
   } bai_status_t;

   typedef struct packed {
      bai_state_t       st;
      bai_op_t          op;
      logic             dest;
      logic [7:0]       acc;
      logic             carry;
      logic             nil;
      logic [1:0][15:0] ptr;
      bai_mem_req_t     mem;
      logic             done;
   } bai_core_state_t;

endpackage

// >>> rtl/bai_core.sv
// Execution datapath for the byte ALU group and the indirect load.
// Assumes data memory samples re/we on the clock edge and returns read data
// in the cycle after re is high; the decoder waits for op_ready.
`timescale 1ns/1ps

module bai_core (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire bai_pkg::bai_op_req_t  op_req,
   output logic                       op_ready,
   output logic                       op_done,
   input  wire bai_pkg::bai_preset_t  preset,
   output bai_pkg::bai_mem_req_t      mem_req,
   input  wire logic [7:0]            mem_rdata,
   output bai_pkg::bai_status_t       status
);

   // ************************************************************
   // State
   // ************************************************************
   bai_pkg::bai_core_state_t s_r;
   bai_pkg::bai_core_state_t s_nxt;

   logic [15:0] cur_ptr;
   logic [15:0] new_ptr;
   logic [15:0] eff_addr;
   logic [15:0] rel_off;
   logic [7:0]  result;
   logic        res_carry;
   logic        carry_hit;

   // op_ready is combinational; op_done and everything else leave from flip-flops
   assign op_ready     = (s_r.st == bai_pkg::ST_IDLE);
   assign op_done      = s_r.done;
   assign mem_req      = s_r.mem;
   assign status.acc   = s_r.acc;
   assign status.carry = s_r.carry;
   assign status.nil   = s_r.nil;
   assign status.ptr0  = s_r.ptr[0];
   assign status.ptr1  = s_r.ptr[1];

   // ************************************************************
   // Address generation
   // ************************************************************
   // Pointer and effective address for the request on offer
   always_comb begin
      cur_ptr  = s_r.ptr[op_req.ptr_sel];
      rel_off  = {{10{op_req.offset[5]}}, op_req.offset};
      new_ptr  = cur_ptr;
      eff_addr = {bai_pkg::LOC_EXT, op_req.loc};
      if (op_req.op == bai_pkg::OP_LOAD_INDIR) begin
         if (op_req.rel) begin
            eff_addr = cur_ptr + rel_off;                         // RQ10 RQ11
            new_ptr  = cur_ptr;                                   // RQ10
         end else begin
            unique case (op_req.upd)
               bai_pkg::UPD_PRE_INC: begin
                  new_ptr  = cur_ptr + bai_pkg::PTR_STEP;         // RQ9 RQ11
                  eff_addr = new_ptr;
               end
               bai_pkg::UPD_PRE_DEC: begin
                  new_ptr  = cur_ptr - bai_pkg::PTR_STEP;         // RQ9 RQ11
                  eff_addr = new_ptr;
               end
               bai_pkg::UPD_POST_INC: begin
                  new_ptr  = cur_ptr + bai_pkg::PTR_STEP;         // RQ9 RQ11
                  eff_addr = cur_ptr;
               end
               bai_pkg::UPD_POST_DEC: begin
                  new_ptr  = cur_ptr - bai_pkg::PTR_STEP;         // RQ9 RQ11
                  eff_addr = cur_ptr;
               end
            endcase
         end
      end else if (op_req.loc == bai_pkg::WIN0_LOC) begin
         eff_addr = s_r.ptr[0];                                   // RQ7
      end else if (op_req.loc == bai_pkg::WIN1_LOC) begin
         eff_addr = s_r.ptr[1];                                   // RQ7
      end
   end

   // ************************************************************
   // Arithmetic and logic
   // ************************************************************
   // Result from the byte read in the execute cycle
   always_comb begin
      result    = mem_rdata;
      res_carry = s_r.carry;
      carry_hit = 1'b0;
      unique case (s_r.op)
         bai_pkg::OP_INCREMENT: begin
            result = mem_rdata + 8'h01;                           // RQ2
         end
         bai_pkg::OP_OR_ACCUM: begin
            result = s_r.acc | mem_rdata;                         // RQ3
         end
         bai_pkg::OP_SHIFT_LEFT: begin
            result    = {mem_rdata[6:0], 1'b0};                   // RQ4
            res_carry = mem_rdata[7];                             // RQ4
            carry_hit = 1'b1;
         end
         bai_pkg::OP_SHIFT_RGHT: begin
            result    = {1'b0, mem_rdata[7:1]};                   // RQ5
            res_carry = mem_rdata[0];                             // RQ5
            carry_hit = 1'b1;
         end
         bai_pkg::OP_COPY_FILE: begin
            result = mem_rdata;                                   // RQ6
         end
         bai_pkg::OP_LOAD_INDIR: begin
            result = mem_rdata;                                   // RQ8
         end
         default: begin
            result = mem_rdata;
         end
      endcase
   end

   // ************************************************************
   // Sequencer
   // ************************************************************
   // Idle takes a request, fetch waits on memory, execute retires
   always_comb begin
      s_nxt          = s_r;
      s_nxt.mem.re   = 1'b0;
      s_nxt.mem.we   = 1'b0;
      s_nxt.done     = 1'b0;
      unique case (s_r.st)
         bai_pkg::ST_IDLE: begin
            if (op_req.valid) begin
               s_nxt.op       = op_req.op;
               s_nxt.dest     = op_req.dest;                      // RQ1
               s_nxt.mem.addr = eff_addr;
               s_nxt.mem.re   = 1'b1;
               s_nxt.st       = bai_pkg::ST_FETCH;
               if (op_req.op == bai_pkg::OP_LOAD_INDIR) begin
                  // Flags stay as they are while the pointer moves
                  s_nxt.ptr[op_req.ptr_sel] = new_ptr;            // RQ9 RQ12
                  s_nxt.dest                = 1'b0;               // RQ8
               end
            end else if (preset.valid) begin
               // Preload is only honoured while no request competes
               unique case (preset.target)
                  bai_pkg::PRE_ACC:  s_nxt.acc    = preset.data[7:0];
                  bai_pkg::PRE_PTR0: s_nxt.ptr[0] = preset.data;
                  bai_pkg::PRE_PTR1: s_nxt.ptr[1] = preset.data;
                  default:           s_nxt.acc    = s_r.acc;
               endcase
            end
         end
         bai_pkg::ST_FETCH: begin
            s_nxt.st = bai_pkg::ST_EXEC;
         end
         bai_pkg::ST_EXEC: begin
            if (s_r.dest) begin
               // Write back goes to the same address that was read
               s_nxt.mem.we    = 1'b1;                            // RQ1 RQ7
               s_nxt.mem.wdata = result;
            end else begin
               s_nxt.acc = result;                                // RQ1 RQ8
            end
            s_nxt.nil = (result == bai_pkg::NIL_VALUE);           // RQ13 RQ6 RQ12
            if (carry_hit) begin
               s_nxt.carry = res_carry;                           // RQ13
            end
            s_nxt.done = 1'b1;
            s_nxt.st   = bai_pkg::ST_IDLE;
         end
         default: begin
            // Code 2'h2 is unused; fall back to idle
            s_nxt.st = bai_pkg::ST_IDLE;
         end
      endcase
   end

   // ************************************************************
   // State register
   // ************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r.st        <= bai_pkg::ST_IDLE;
         s_r.op        <= bai_pkg::OP_INCREMENT;
         s_r.dest      <= 1'b0;
         s_r.acc       <= bai_pkg::ACC_RST;
         s_r.carry     <= bai_pkg::CARRY_RST;
         s_r.nil       <= bai_pkg::NIL_RST;
         s_r.ptr[0]    <= bai_pkg::PTR_RST;
         s_r.ptr[1]    <= bai_pkg::PTR_RST;
         s_r.mem.re    <= 1'b0;
         s_r.mem.we    <= 1'b0;
         s_r.mem.addr  <= bai_pkg::PTR_RST;
         s_r.mem.wdata <= bai_pkg::ACC_RST;
         s_r.done      <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// >>> verif/bai_core_monitor.sv
// Port checker for bai_core: timing of a taken request and its results.
// Assumes the bind below reaches every bai_core instance.
`timescale 1ns/1ps
module bai_core_monitor (
   input wire logic                  core_clk,
   input wire logic                  rst_n,
   input wire bai_pkg::bai_op_req_t  op_req,
   input wire logic                  op_ready,
   input wire logic                  op_done,
   input wire bai_pkg::bai_preset_t  preset,
   input wire bai_pkg::bai_mem_req_t mem_req,
   input wire logic [7:0]            mem_rdata,
   input wire bai_pkg::bai_status_t  status
);
   // ****
   // Properties
   // ****
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic tk;
   logic ld;
   // Taken request, and a taken indirect load
   assign tk = op_ready && op_req.valid;
   assign ld = tk && op_req.op == bai_pkg::OP_LOAD_INDIR;
   property p_done; tk |=> mem_req.re && !op_ready ##1 !op_ready ##1 op_done && op_ready; endproperty
   a_done: assert property (p_done) else $error("op not retired three cycles after take");
   property p_shl; tk && op_req.op == bai_pkg::OP_SHIFT_LEFT && op_req.dest |-> ##3 mem_req.we &&
      mem_req.wdata == {$past(mem_rdata[6:0]), 1'h0} && status.carry == $past(mem_rdata[7]); endproperty
   a_shl: assert property (p_shl) else $error("left shift result wrong");
   property p_shr; tk && op_req.op == bai_pkg::OP_SHIFT_RGHT && !op_req.dest |-> ##3 !mem_req.we &&
      status.acc == {1'h0, $past(mem_rdata[7:1])} && status.carry == $past(mem_rdata[0]); endproperty
   a_shr: assert property (p_shr) else $error("right shift result wrong");
   property p_nacc; op_done && !mem_req.we |-> status.nil == (status.acc == 8'h00); endproperty
   a_nacc: assert property (p_nacc) else $error("nil flag disagrees with accumulator");
   property p_nwb; op_done && mem_req.we |-> status.nil == (mem_req.wdata == 8'h00); endproperty
   a_nwb: assert property (p_nwb) else $error("nil flag disagrees with write-back");
   // Carry may only move on the two shifts
   property p_cy; tk && op_req.op != bai_pkg::OP_SHIFT_LEFT && op_req.op != bai_pkg::OP_SHIFT_RGHT
      |=> $stable(status.carry) [*3]; endproperty
   a_cy: assert property (p_cy) else $error("carry changed on a non-shift op");
   property p_pre; ld && !op_req.rel && !op_req.ptr_sel && op_req.upd == bai_pkg::UPD_PRE_INC
      |=> status.ptr0 == $past(status.ptr0) + 16'h0001 && mem_req.addr == status.ptr0; endproperty
   a_pre: assert property (p_pre) else $error("pre-increment address wrong");
   property p_rel; ld && op_req.rel && op_req.ptr_sel |=> $stable(status.ptr1) && mem_req.addr ==
      $past(status.ptr1) + {{10{$past(op_req.offset[5])}}, $past(op_req.offset)}; endproperty
   a_rel: assert property (p_rel) else $error("relative address wrong");
   property p_flg; ld |=> $stable(status.nil) ##1 $stable(status.nil); endproperty
   a_flg: assert property (p_flg) else $error("pointer move touched nil");
   property p_win; tk && op_req.op != bai_pkg::OP_LOAD_INDIR && op_req.loc == bai_pkg::WIN1_LOC
      |=> mem_req.addr == status.ptr1 && $stable(status.ptr1); endproperty
   a_win: assert property (p_win) else $error("window did not use pointer");
   c_load: cover property (ld);
   c_wb: cover property (op_done && mem_req.we);
   c_rel: cover property (ld && op_req.rel);
endmodule

bind bai_core bai_core_monitor i_bai_core_monitor (.core_clk, .rst_n, .op_req, .op_ready, .op_done, .preset,
   .mem_req, .mem_rdata, .status);

// >>> verif/bai_core_test.sv
// Self-checking bench for bai_core: ALU ops, windows and pointer modes.
// Assumes the bound monitor and a memory answering one cycle after re.
`timescale 1ns/1ps
module bai_core_test;
   logic                  core_clk;
   logic                  rst_n;
   bai_pkg::bai_op_req_t  op_req;
   logic                  op_ready;
   logic                  op_done;
   bai_pkg::bai_preset_t  preset;
   bai_pkg::bai_mem_req_t mem_req;
   logic [7:0]            mem_rdata;
   bai_pkg::bai_status_t  status;
   logic [7:0]            rd_val;
   int                    num_errors = 0;
   int                    num_checks = 0;

   bai_core i_bai_core (.core_clk, .rst_n, .op_req, .op_ready, .op_done, .preset, .mem_req, .mem_rdata, .status);

   // ****
   // Clock and memory
   // ****
   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Inverse when not read, so stale data never passes for a match
   always @(posedge core_clk) begin
      mem_rdata <= mem_req.re ? rd_val : ~rd_val;
   end

   // ****
   // Shared tasks
   // ****
   task automatic compare(string name, logic [15:0] seen, logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic put(bai_pkg::bai_pre_t t, logic [15:0] v);
      @(posedge core_clk);
      preset <= '{1'h1, t, v};
      @(posedge core_clk);
      preset.valid <= 1'h0;
   endtask
   // One op, whole; result sits in wdata on write-back, else in the accumulator
   task automatic run_op(bai_pkg::bai_op_t o, logic [6:0] l, logic d, logic [7:0] rd, logic [15:0] ea,
                         logic [7:0] res, logic cy, logic s = 1'h0, logic r = 1'h0,
                         bai_pkg::bai_upd_t u = bai_pkg::UPD_PRE_INC, logic [5:0] f = 6'h00);
      logic wb;
      wb = d && o != bai_pkg::OP_LOAD_INDIR;
      @(posedge core_clk);
      op_req <= '{1'h1, o, l, d, s, r, u, f};
      rd_val <= rd;
      @(posedge core_clk);
      op_req.valid <= 1'h0;
      #1 compare("addr", mem_req.addr, ea);
      repeat (2) @(posedge core_clk);
      #1 compare("done", {15'h0000, op_done}, 16'h0001);
      compare("we", {15'h0000, mem_req.we}, {15'h0000, wb});
      compare("result", {8'h00, wb ? mem_req.wdata : status.acc}, {8'h00, res});
      compare("nil", {15'h0000, status.nil}, {15'h0000, res == 8'h00});
      compare("carry", {15'h0000, status.carry}, {15'h0000, cy});
   endtask

   // ****
   // Scenarios
   // ****
   task automatic test_alu;
      run_op(bai_pkg::OP_INCREMENT, 7'h20, 1'h1, 8'hFF, 16'h0020, 8'h00, 1'h0);
      run_op(bai_pkg::OP_INCREMENT, 7'h7F, 1'h0, 8'h41, 16'h007F, 8'h42, 1'h0);
      put(bai_pkg::PRE_ACC, 16'h000F);
      run_op(bai_pkg::OP_OR_ACCUM, 7'h10, 1'h0, 8'hA0, 16'h0010, 8'hAF, 1'h0);
      run_op(bai_pkg::OP_OR_ACCUM, 7'h11, 1'h1, 8'h00, 16'h0011, 8'hAF, 1'h0);
      run_op(bai_pkg::OP_SHIFT_LEFT, 7'h22, 1'h1, 8'h81, 16'h0022, 8'h02, 1'h1);
      run_op(bai_pkg::OP_SHIFT_RGHT, 7'h23, 1'h0, 8'h02, 16'h0023, 8'h01, 1'h0);
      run_op(bai_pkg::OP_SHIFT_LEFT, 7'h24, 1'h0, 8'h80, 16'h0024, 8'h00, 1'h1);
      run_op(bai_pkg::OP_COPY_FILE, 7'h25, 1'h1, 8'h00, 16'h0025, 8'h00, 1'h1);
      run_op(bai_pkg::OP_COPY_FILE, 7'h26, 1'h0, 8'h5A, 16'h0026, 8'h5A, 1'h1);
      $display("test_alu finished");
   endtask
   task automatic test_win;
      put(bai_pkg::PRE_PTR1, 16'h1234);
      put(bai_pkg::PRE_PTR0, 16'hABCD);
      run_op(bai_pkg::OP_COPY_FILE, 7'h01, 1'h0, 8'h3C, 16'h1234, 8'h3C, 1'h1);
      run_op(bai_pkg::OP_INCREMENT, 7'h00, 1'h1, 8'h10, 16'hABCD, 8'h11, 1'h1);
      compare("ptr1", status.ptr1, 16'h1234);
      $display("test_win finished");
   endtask
   // Walk all four update codes across both ends of the pointer range
   task automatic test_load;
      logic [15:0] ea[4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
      logic [15:0] pa[4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
      put(bai_pkg::PRE_PTR0, 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         run_op(bai_pkg::OP_LOAD_INDIR, 7'h00, 1'h1, 8'(i), ea[i], 8'(i), 1'h1, 1'h0, 1'h0,
                bai_pkg::bai_upd_t'(i));
         compare("ptr0", status.ptr0, pa[i]);
      end
      $display("test_load finished");
   endtask
   task automatic test_rel;
      put(bai_pkg::PRE_PTR1, 16'h1000);
      run_op(bai_pkg::OP_LOAD_INDIR, 7'h00, 1'h0, 8'hE7, 16'h0FE0, 8'hE7, 1'h1, 1'h1, 1'h1,
             bai_pkg::UPD_POST_DEC, 6'h20);
      run_op(bai_pkg::OP_LOAD_INDIR, 7'h00, 1'h0, 8'h00, 16'h101F, 8'h00, 1'h1, 1'h1, 1'h1,
             bai_pkg::UPD_PRE_INC, 6'h1F);
      compare("ptr1", status.ptr1, 16'h1000);
      $display("test_rel finished");
   endtask
   // Request and preset held while busy must be ignored, not queued
   task automatic test_busy;
      @(posedge core_clk);
      op_req <= '{1'h1, bai_pkg::OP_COPY_FILE, 7'h30, 1'h0, 1'h0, 1'h0, bai_pkg::UPD_PRE_INC, 6'h00};
      rd_val <= 8'h66;
      @(posedge core_clk);
      preset <= '{1'h1, bai_pkg::PRE_ACC, 16'h0099};
      repeat (2) @(posedge core_clk);
      op_req.valid <= 1'h0;
      preset.valid <= 1'h0;
      #1 compare("done", {15'h0000, op_done}, 16'h0001);
      compare("acc", {8'h00, status.acc}, 16'h0066);
      @(posedge core_clk);
      #1 compare("re", {15'h0000, mem_req.re}, 16'h0000);
      compare("acc", {8'h00, status.acc}, 16'h0066);
      $display("test_busy finished");
   endtask

   // ****
   // Main sequence and watchdog
   // ****
   initial begin
      rst_n = 1'h0;
      op_req = '0;
      preset = '0;
      rd_val = 8'h00;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'h1;
      #1 compare("flags", {6'h00, status.carry, status.nil, status.acc}, 16'h0000);
      test_alu();
      test_win();
      test_load();
      test_rel();
      test_busy();
      results();
   end
   // About 18 ops of four cycles each; 20 us leaves ample margin
   initial begin
      #20000;
      num_errors++;
      results();
   end
endmodule
